/* rtl/gtap_pkg.sv */
// package: constants and types for the general-purpose timer block
package gtap_pkg;

  // ****************************************************************
  // widths and channel counts
  // ****************************************************************
  localparam int FRC_W   = 16;  // free-running count width
  localparam int ACC_W   = 8;   // accumulator count width
  localparam int PWM_W   = 8;   // pulse-width counter width
  localparam int N_CAP   = 3;   // capture channels
  localparam int N_CMP   = 5;   // compare channels
  localparam int N_PWM   = 2;   // pulse-width outputs

  // ****************************************************************
  // timing: ratios of the system clock
  // ****************************************************************
  localparam int PHASE_PER_SYS  = 1;  // phase clock runs at sys rate
  localparam int FRC_PHASE_DIV  = 4;  // count advances at phase/4
  localparam int PWM_PHASE_DIV  = 2;  // pwm resolution 2 clocks
  localparam int FRC_DIV_CYC    = FRC_PHASE_DIV * PHASE_PER_SYS;
  localparam int PWM_DIV_CYC    = PWM_PHASE_DIV * PHASE_PER_SYS;
  localparam int FILT_CYC       = 2;  // stable samples to accept a level

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [FRC_W-1:0] FRC_RST = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
  localparam logic [PWM_W-1:0] PWM_RST = 8'h00;

  // ****************************************************************
  // modes
  // ****************************************************************
  typedef enum logic [1:0] {
    GTAP_ACC_OFF,
    GTAP_ACC_EVENT,
    GTAP_ACC_GATED,
    GTAP_ACC_OVF
  } gtap_acc_mode_e;

  typedef enum logic [1:0] {
    GTAP_EDGE_OFF,
    GTAP_EDGE_RISE,
    GTAP_EDGE_FALL,
    GTAP_EDGE_BOTH
  } gtap_edge_e;

endpackage : gtap_pkg

/* rtl/gtap_cond.sv */
// module: input conditioner, two-stage synchronizer plus digital filter
`timescale 1ns/1ps
`default_nettype none

module gtap_cond
  import gtap_pkg::*;
#(
  parameter int FILT = gtap_pkg::FILT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic raw,
  output var  logic cond_q
);

  localparam int CW = $clog2(FILT + 1);

  logic          meta_q;
  logic          sync_q;
  logic [CW-1:0] run_q;
  logic [CW-1:0] run_d;
  logic          flip;

  // ****************************************************************
  // synchronizer: meta_q feeds only sync_q
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  // filter: a new level must hold FILT samples, rejecting short glitches
  assign flip  = (sync_q != cond_q) && (run_q == CW'(FILT - 1));
  assign run_d = (sync_q == cond_q || flip) ? '0 : run_q + 1'b1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q  <= '0;
      cond_q <= 1'b0;
    end else begin
      run_q  <= run_d;
      cond_q <= flip ? sync_q : cond_q;
    end
  end

endmodule : gtap_cond

`default_nettype wire

/* rtl/gtap_timer.sv */
// module: timer with capture, compare, pulse accumulator and pwm
// Notes on behaviour
// - event mode: each leading edge bumps accumulator and sets edge flag
// - accumulator wrapping from all ones to zero sets overflow flag
// - gated mode counts while input at its active level; flag set when gate ends
// - overflow-gated: count only on free-running wrap with input at its active level
// - free-running count advances every fourth phase clock
// - fast pwm: high when counter wraps to zero, low at duty match
// - compare match sets flag first, then toggles pin next cycle
// - selected capture edge latches count and sets flag same cycle
// - every capture and accumulator pin input passes synchronizer then filter before use
// - capture pin driven as output is seen by its own input path
`timescale 1ns/1ps
`default_nettype none

module gtap_timer
  import gtap_pkg::*;
#(
  parameter int NCAP = gtap_pkg::N_CAP,
  parameter int NCMP = gtap_pkg::N_CMP,
  parameter int NPWM = gtap_pkg::N_PWM
) (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  // capture pins and their general-purpose output use
  input  wire logic [NCAP-1:0]                   cap_pin_in,
  output var  logic [NCAP-1:0]                   cap_pin_out_q,
  output var  logic [NCAP-1:0]                   cap_pin_oe_b_q,
  input  wire logic [NCAP-1:0]                   cap_gpo_en,
  input  wire logic [NCAP-1:0]                   cap_gpo_val,
  input  wire gtap_pkg::gtap_edge_e [NCAP-1:0]   cap_edge_sel,
  output var  logic [NCAP-1:0][gtap_pkg::FRC_W-1:0] cap_value_q,
  output var  logic [NCAP-1:0]                   capture_flag_q,
  input  wire logic [NCAP-1:0]                   capture_flag_clr,
  // compare channels
  input  wire logic [NCMP-1:0][gtap_pkg::FRC_W-1:0] cmp_value,
  output var  logic [NCMP-1:0]                   compare_channel_q,
  output var  logic [NCMP-1:0]                   cmp_flag_q,
  input  wire logic [NCMP-1:0]                   cmp_flag_clr,
  // pulse accumulator
  input  wire logic                              accum_input_pin,
  input  wire gtap_pkg::gtap_acc_mode_e          accum_mode,
  input  wire logic                              accum_rise_sel,
  output var  logic [gtap_pkg::ACC_W-1:0]        accum_count_q,
  output var  logic                              accum_edge_flag_q,
  input  wire logic                              accum_edge_clr,
  output var  logic                              accum_overflow_flag_q,
  input  wire logic                              accum_ovf_clr,
  // pulse-width outputs
  input  wire logic [NPWM-1:0][gtap_pkg::PWM_W-1:0] pwm_duty,
  output var  logic [NPWM-1:0]                   pulse_width_output_q,
  // free-running count
  output var  logic [gtap_pkg::FRC_W-1:0]        free_running_count_q
);

  localparam int PW = $clog2(FRC_DIV_CYC);
  localparam int QW = $clog2(PWM_DIV_CYC);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_m_q;
  logic rst_s_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // ****************************************************************
  // prescalers and free-running count
  // ****************************************************************
  logic [PW-1:0] presc_q;
  logic [QW-1:0] pwdiv_q;
  logic          frc_tick;
  logic          pwm_tick;
  logic          frc_wrap;

  assign frc_tick = (presc_q == PW'(FRC_DIV_CYC - 1));
  assign pwm_tick = (pwdiv_q == QW'(PWM_DIV_CYC - 1));
  assign frc_wrap = frc_tick && (free_running_count_q == '1);

  // count only on the divided enable, one clock domain throughout
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      presc_q              <= '0;
      pwdiv_q              <= '0;
      free_running_count_q <= FRC_RST;
    end else begin
      presc_q              <= frc_tick ? '0 : presc_q + 1'b1;
      pwdiv_q              <= pwm_tick ? '0 : pwdiv_q + 1'b1;
      if (frc_tick)
        free_running_count_q <= free_running_count_q + 1'b1;
    end
  end

  // ****************************************************************
  // capture channels
  // ****************************************************************
  for (genvar i = 0; i < NCAP; i++) begin : g_cap
    logic seen;
    logic flt;
    logic flt_prev_q;
    logic rise;
    logic fall;
    logic hit;

    // a driven pin is read back from its own output register, not the pad
    assign seen = cap_pin_oe_b_q[i] ? cap_pin_in[i]
                                    : cap_pin_out_q[i];

    gtap_cond u_cond (
      .clk    (clk),
      .rst_b  (rst_s_q),
      .raw    (seen),
      .cond_q (flt)
    );

    assign rise = flt && !flt_prev_q;
    assign fall = !flt && flt_prev_q;
    assign hit  = (cap_edge_sel[i] == GTAP_EDGE_RISE && rise) ||
                  (cap_edge_sel[i] == GTAP_EDGE_FALL && fall) ||
                  (cap_edge_sel[i] == GTAP_EDGE_BOTH && (rise || fall));

    always_ff @(posedge clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
        flt_prev_q        <= 1'b0;
        cap_value_q[i]    <= FRC_RST;
        capture_flag_q[i] <= 1'b0;
        cap_pin_out_q[i]  <= 1'b0;
        cap_pin_oe_b_q[i] <= 1'b1;
      end else begin
        flt_prev_q        <= flt;
        cap_pin_out_q[i]  <= cap_gpo_val[i];
        cap_pin_oe_b_q[i] <= !cap_gpo_en[i];
        if (hit)
          cap_value_q[i] <= free_running_count_q;
        // set beats a clear in the same cycle
        capture_flag_q[i] <= hit ||
          (capture_flag_q[i] && !capture_flag_clr[i]);
      end
    end
  end

  // ****************************************************************
  // compare channels
  // ****************************************************************
  for (genvar j = 0; j < NCMP; j++) begin : g_cmp
    logic match;
    logic pend_q;

    assign match = frc_tick && (free_running_count_q == cmp_value[j]);

    // flag first; the pin follows one clock later
    always_ff @(posedge clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
        pend_q               <= 1'b0;
        cmp_flag_q[j]        <= 1'b0;
        compare_channel_q[j] <= 1'b0;
      end else begin
        pend_q        <= match;
        cmp_flag_q[j] <= match ||
          (cmp_flag_q[j] && !cmp_flag_clr[j]);
        if (pend_q)
          compare_channel_q[j] <= !compare_channel_q[j];
      end
    end
  end

  // ****************************************************************
  // pulse accumulator
  // ****************************************************************
  logic acc_flt;
  logic acc_prev_q;
  logic acc_active;
  logic acc_lead;
  logic acc_trail;
  logic acc_inc;
  logic acc_evt;

  gtap_cond u_acc_cond (
    .clk    (clk),
    .rst_b  (rst_s_q),
    .raw    (accum_input_pin),
    .cond_q (acc_flt)
  );

  assign acc_active = accum_rise_sel ? acc_flt : !acc_flt;
  assign acc_lead   = acc_active && !(accum_rise_sel ? acc_prev_q
                                                     : !acc_prev_q);
  assign acc_trail  = !acc_active && (accum_rise_sel ? acc_prev_q
                                                     : !acc_prev_q);

  // increment and flag sources per mode
  always_comb begin
    acc_inc = 1'b0;
    acc_evt = 1'b0;
    unique case (accum_mode)
      GTAP_ACC_OFF: begin
        acc_inc = 1'b0;
      end
      GTAP_ACC_EVENT: begin
        acc_inc = acc_lead;
        acc_evt = acc_lead;
      end
      GTAP_ACC_GATED: begin
        acc_inc = frc_tick && acc_active;
        acc_evt = acc_trail;
      end
      GTAP_ACC_OVF: begin
        acc_inc = frc_wrap && acc_active;
        acc_evt = acc_trail;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      acc_prev_q            <= 1'b0;
      accum_count_q         <= ACC_RST;
      accum_edge_flag_q     <= 1'b0;
      accum_overflow_flag_q <= 1'b0;
    end else begin
      acc_prev_q <= acc_flt;
      if (acc_inc)
        accum_count_q <= accum_count_q + 1'b1;
      accum_edge_flag_q <= acc_evt ||
        (accum_edge_flag_q && !accum_edge_clr);
      accum_overflow_flag_q <= (acc_inc && accum_count_q == '1) ||
        (accum_overflow_flag_q && !accum_ovf_clr);
    end
  end

  // ****************************************************************
  // fast-mode pulse-width outputs
  // ****************************************************************
  logic [PWM_W-1:0] pwm_cnt_q;
  logic [PWM_W-1:0] pwm_nxt;

  assign pwm_nxt = pwm_cnt_q + 1'b1;

  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q)
      pwm_cnt_q <= PWM_RST;
    else if (pwm_tick)
      pwm_cnt_q <= pwm_nxt;
  end

  for (genvar k = 0; k < NPWM; k++) begin : g_pwm
    // a duty of zero wins over the wrap, so the output stays low
    always_ff @(posedge clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
        pulse_width_output_q[k] <= 1'b0;
      end else if (pwm_tick) begin
        if (pwm_nxt == pwm_duty[k])
          pulse_width_output_q[k] <= 1'b0;
        else if (pwm_nxt == '0)
          pulse_width_output_q[k] <= 1'b1;
      end
    end
  end

endmodule : gtap_timer

`default_nettype wire

/* testbench/gtap_pad_model.sv */
// partner: external source on the capture pads
`timescale 1ns/1ps
`default_nettype none
module gtap_pad_model #(
  parameter int NCAP = 3
) (
  input  wire logic [NCAP-1:0] pad_oe_b,
  input  wire logic [NCAP-1:0] pad_out,
  input  wire logic [NCAP-1:0] ext_drive,
  output wire logic [NCAP-1:0] pad_level
);
  // pad follows the chip while enabled, so its own drive is read back
  assign pad_level = (~pad_oe_b & pad_out) | (pad_oe_b & ext_drive);
endmodule : gtap_pad_model
`default_nettype wire

/* testbench/gtap_checker.sv */
// checker: timer port assertions
`timescale 1ns/1ps
`default_nettype none
module gtap_checker
  import gtap_pkg::*;
#(
  parameter int NCAP = 3,
  parameter int NCMP = 5,
  parameter int NPWM = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NCAP-1:0][gtap_pkg::FRC_W-1:0] cap_value_q,
  input wire logic [NCAP-1:0] capture_flag_q,
  input wire logic [NCAP-1:0] capture_flag_clr,
  input wire logic [NCMP-1:0] compare_channel_q,
  input wire logic [NCMP-1:0] cmp_flag_q,
  input wire gtap_pkg::gtap_acc_mode_e accum_mode,
  input wire logic [gtap_pkg::ACC_W-1:0] accum_count_q,
  input wire logic accum_edge_flag_q,
  input wire logic accum_overflow_flag_q,
  input wire logic [NPWM-1:0][gtap_pkg::PWM_W-1:0] pwm_duty,
  input wire logic [NPWM-1:0] pulse_width_output_q,
  input wire logic [gtap_pkg::FRC_W-1:0] free_running_count_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [9:0] hcnt_q;
  // ********
  // high time of pwm 0; a duty change mid-pulse would skew it
  // ********
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      hcnt_q <= '0;
    else if (pulse_width_output_q[0])
      hcnt_q <= hcnt_q + 10'h001;
    else
      hcnt_q <= '0;
  end
  sequence s_hold3;
    $stable(free_running_count_q)[*3];
  endsequence
  sequence s_toggle;
    ##1 $changed(compare_channel_q[0]);
  endsequence
  a_frc_rate:
    assert property ($changed(free_running_count_q) |=> s_hold3 ##1
      free_running_count_q == $past(free_running_count_q) + 16'h0001)
    else $error("count step spacing wrong");
  a_cmp_order:
    assert property ($rose(cmp_flag_q[0]) |-> s_toggle)
    else $error("compare pin did not follow flag");
  a_cap_flag:
    assert property ($changed(cap_value_q[0]) |-> capture_flag_q[0])
    else $error("capture without flag");
  a_cap_value:
    assert property ($changed(cap_value_q[0]) |->
      free_running_count_q - cap_value_q[0] <= 16'h0001)
    else $error("captured value not current count");
  a_flag_sticky:
    assert property ($fell(capture_flag_q[0]) |-> $past(capture_flag_clr[0]))
    else $error("capture flag lost without clear");
  a_ovf_flag:
    assert property ($past(accum_count_q) == 8'hff && accum_count_q == 8'h00
      |-> ##[0:1] accum_overflow_flag_q)
    else $error("wrap without overflow flag");
  a_evt_flag:
    assert property (accum_mode == GTAP_ACC_EVENT && $changed(accum_count_q)
      |-> accum_edge_flag_q)
    else $error("event count without flag");
  a_ovf_gate:
    assert property (accum_mode == GTAP_ACC_OVF && $changed(accum_count_q)
      |-> free_running_count_q <= 16'h0001)
    else $error("gated count off the wrap");
  a_pwm_high:
    assert property ($fell(pulse_width_output_q[0]) |->
      hcnt_q == {1'b0, pwm_duty[0], 1'b0})
    else $error("pwm high time wrong");
endmodule : gtap_checker
bind gtap_timer gtap_checker #(.NCAP(NCAP), .NCMP(NCMP), .NPWM(NPWM))
  gtap_checker_i (.clk, .rst_b, .cap_value_q, .capture_flag_q,
  .capture_flag_clr, .compare_channel_q, .cmp_flag_q, .accum_mode,
  .accum_count_q, .accum_edge_flag_q, .accum_overflow_flag_q, .pwm_duty,
  .pulse_width_output_q, .free_running_count_q);
`default_nettype wire

/* testbench/testbench.sv */
// testbench: self-checking run of the timer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gtap_pkg::*;
  logic clk, rst_b = 0, acc_in = 0, rsel = 1, aef, aof, aclr = 0, oclr = 0;
  logic [N_CAP-1:0] ext_q = 0, pad, pout, oe_b, gen = 0, gval = 0, cf;
  logic [N_CAP-1:0] cclr = 0;
  logic [N_CAP-1:0][FRC_W-1:0] capv;
  logic [N_CMP-1:0][FRC_W-1:0] cmpv = '1;
  logic [N_CMP-1:0] cpin, cflg, kclr = 0;
  logic [N_PWM-1:0][PWM_W-1:0] duty;
  logic [N_PWM-1:0] pwm;
  logic [ACC_W-1:0] acnt;
  logic [FRC_W-1:0] frc, f0, v;
  logic [31:0] h;
  gtap_edge_e [N_CAP-1:0] esel = '{default: GTAP_EDGE_OFF};
  gtap_acc_mode_e amode = GTAP_ACC_OFF;
  integer seed = 32'h257d0c33;
  int err_count = 0, n_tests = 0, cyc = 0, n;
  // compare model: the value each channel waits for, highest channel first
  int cmp_mdl[$];
  gtap_timer gtap_timer_i (.clk(clk), .rst_b(rst_b), .cap_pin_in(pad),
    .cap_pin_out_q(pout), .cap_pin_oe_b_q(oe_b), .cap_gpo_en(gen),
    .cap_gpo_val(gval), .cap_edge_sel(esel), .cap_value_q(capv),
    .capture_flag_q(cf), .capture_flag_clr(cclr), .cmp_value(cmpv),
    .compare_channel_q(cpin), .cmp_flag_q(cflg), .cmp_flag_clr(kclr),
    .accum_input_pin(acc_in), .accum_mode(amode), .accum_rise_sel(rsel),
    .accum_count_q(acnt), .accum_edge_flag_q(aef), .accum_edge_clr(aclr),
    .accum_overflow_flag_q(aof), .accum_ovf_clr(oclr), .pwm_duty(duty),
    .pulse_width_output_q(pwm), .free_running_count_q(frc));
  gtap_pad_model gtap_pad_model_i (.pad_oe_b(oe_b), .pad_out(pout),
    .ext_drive(ext_q), .pad_level(pad));
  // ********
  // clock, hang guard and helpers
  // ********
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      print_verdict;
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask : step
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic do_reset;
    rst_b <= 1'b0;
    step(6);
    rst_b <= 1'b1;
    step(4);
  endtask : do_reset
  task automatic print_verdict;
    $display("TB: %0d checks, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // ********
  // main sequence
  // ********
  initial begin
    duty[0] <= 8'(1 + $unsigned($random(seed)) % 255);
    duty[1] <= 8'h00;
    do_reset;
    f0 = frc;
    step(40);
    chk(frc - f0, 40 / FRC_DIV_CYC);
    foreach (cmpv[j]) begin
      v = frc + 16'(3 + $unsigned($random(seed)) % 8);
      cmpv[j] <= v;
      cmp_mdl.push_back(v);
    end
    step(60);
    // a channel has fired once the count has moved past its value
    foreach (cmp_mdl[j]) begin
      chk(cflg[j], frc > cmp_mdl[j]);
      chk(cpin[j], frc > cmp_mdl[j] + 1);
    end
    kclr <= '1;
    step(1);
    kclr <= '0;
    step(2);
    chk(cflg, 0);
    $display("TB: count and compare done");
    // every edge select on every pad, then a glitch and own readback
    for (int i = 0; i < N_CAP; i++) begin
      for (int e = 0; e < 4; e++) begin
        esel[i] <= gtap_edge_e'(e);
        f0 = frc;
        ext_q[i] <= 1'b1;
        step(12);
        chk(cf[i], e == GTAP_EDGE_RISE || e == GTAP_EDGE_BOTH);
        ext_q[i] <= 1'b0;
        step(12);
        chk(cf[i], e != GTAP_EDGE_OFF);
        if (e != 0) chk(capv[i] - f0 <= frc - f0, 1);
        cclr[i] <= 1'b1;
        step(1);
        cclr[i] <= 1'b0;
        step(2);
        chk(cf[i], 0);
      end
      esel[i] <= GTAP_EDGE_BOTH;
      ext_q[i] <= 1'b1;
      step(1);
      ext_q[i] <= 1'b0;
      step(12);
      chk(cf[i], 0);
      esel[i] <= GTAP_EDGE_RISE;
      gval[i] <= 1'b1;
      gen[i] <= 1'b1;
      step(14);
      chk({oe_b[i], pout[i], cf[i]}, 3'b011);
      gen[i] <= 1'b0;
      gval[i] <= 1'b0;
      esel[i] <= GTAP_EDGE_OFF;
      step(12);
    end
    $display("TB: capture done");
    do_reset;
    amode <= GTAP_ACC_EVENT;
    n = 254 + $unsigned($random(seed)) % 6;
    repeat (n) begin
      acc_in <= 1'b1;
      step(4);
      acc_in <= 1'b0;
      step(4);
    end
    step(12);
    chk(acnt, n % 256);
    chk({aef, aof}, {1'b1, n > 255});
    aclr <= 1'b1;
    oclr <= 1'b1;
    step(1);
    aclr <= 1'b0;
    oclr <= 1'b0;
    step(2);
    chk({aef, aof}, 0);
    h = 0;
    // one whole period: pwm 1 has zero duty and must stay low
    repeat (512) begin
      step(1);
      h = h + {pwm[1], 9'h000} + pwm[0];
    end
    chk(h, 2 * duty[0]);
    $display("TB: event count and pwm done");
    do_reset;
    amode <= GTAP_ACC_GATED;
    acc_in <= 1'b1;
    step(80);
    chk(aef, 0);
    acc_in <= 1'b0;
    step(12);
    chk(aef, 1);
    chk(acnt >= 19 && acnt <= 21, 1);
    do_reset;
    amode <= GTAP_ACC_OVF;
    acc_in <= 1'b1;
    step(100);
    chk(acnt, 0);
    // inverted sense: falls lead, so four falls and three rises give four
    rsel <= 1'b0;
    amode <= GTAP_ACC_EVENT;
    repeat (3) begin
      acc_in <= 1'b0;
      step(4);
      acc_in <= 1'b1;
      step(4);
    end
    acc_in <= 1'b0;
    step(12);
    chk(acnt, 4);
    chk(aef, 1);
    $display("TB: gated modes done");
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
